// ---- src/adcs_top.sv ----
// audio dma channel setup registers, per-channel address engines and word fifos
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "adcs_cfg.svh"

// ************************************************************
// word fifo, registered outputs
// ************************************************************
module adcs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = `ADCS_FIFO_DEPTH
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             flush_i,
  input  wire logic             block_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  output logic      [WIDTH-1:0] rd_data_o,
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [CW-1:0]    count_q;
  logic [CW-1:0]    count_d;
  logic [CW-1:0]    wpos;
  logic             push;
  logic             pop;

  assign push = wr_valid_i & wr_ready_o & ~flush_i;
  assign pop  = rd_valid_o & rd_ready_i & ~flush_i;
  // with a pop the whole queue shifts down, so the tail slot moves too
  assign wpos = pop ? CW'(count_q - CW'(1)) : count_q;

  always_comb begin
    if (flush_i) begin
      count_d = '0;
    end else begin
      count_d = CW'(count_q + CW'(push) - CW'(pop));
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      count_q    <= '0;
      rd_valid_o <= 1'b0;
      wr_ready_o <= 1'b0;
    end else begin
      count_q    <= count_d;
      rd_valid_o <= (count_d != '0);
      wr_ready_o <= ~block_i & (count_d < CW'(DEPTH));
    end
  end

  // shift register keeps the head in a flop, so the read port needs no mux
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        mem_q[i] <= '0;
      end else if (push && (wpos == CW'(i))) begin
        mem_q[i] <= wr_data_i;
      end else if (pop) begin
        if (i < DEPTH - 1) begin
          mem_q[i] <= mem_q[(i < DEPTH - 1) ? i + 1 : i];
        end
      end
    end
  end

  assign rd_data_o = mem_q[0];

endmodule : adcs_fifo

// ************************************************************
// top: registers, channel engines, memory port
// ************************************************************
module adcs_top #(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 16,
  parameter int DEPTH  = `ADCS_FIFO_DEPTH
) (
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,
  input  wire logic [ADDR_W-1:0]         reg_addr_i,
  input  wire logic [15:0]               reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output logic      [15:0]               reg_rdata_o,
  input  wire logic [31:0]               mic_primary_addr_i,
  input  wire logic [31:0]               mic_secondary_addr_i,
  input  wire logic                      mic_autoload_select_i,
  input  wire logic                      speaker_autoload_select_i,
  output adcs_pkg::adcs_mem_cmd_type     mem_cmd_o,
  input  wire logic                      mem_gnt_i,
  input  wire logic                      mem_rvalid_i,
  input  wire logic [DATA_W-1:0]         mem_rdata_i,
  output logic      [DATA_W-1:0]         spk_data_o,
  output logic                           spk_valid_o,
  input  wire logic                      spk_ready_i,
  input  wire logic [DATA_W-1:0]         mic_data_i,
  input  wire logic                      mic_valid_i,
  output logic                           mic_ready_o,
  output logic                           spk_end_o,
  output logic                           mic_end_o
);

  // ************************************************************
  // setup registers
  // ************************************************************
  logic [15:0] spk_pri_lo_q;
  logic [15:0] spk_pri_hi_q;
  logic [15:0] spk_sec_lo_q;
  logic [15:0] spk_sec_hi_q;
  logic        dma_hold_n_q;
  logic        mic_channel_enable_q;
  logic        speaker_channel_enable_q;
  logic [15:0] mic_word_count_q;
  logic [15:0] speaker_word_count_q;
  logic [15:0] rdata_d;
  logic        wr_lock;
  logic        wr_ok;

  // per channel: index 0 speaker, index 1 microphone
  logic [31:0] ch_pri   [2];
  logic [31:0] ch_sec   [2];
  logic [15:0] ch_cnt   [2];
  logic [31:0] ch_addr  [2];
  logic [1:0]  ch_auto;
  logic [1:0]  ch_en;
  logic [1:0]  ch_run;
  logic [1:0]  ch_sel;
  logic [1:0]  ch_end;
  logic [1:0]  ch_done;

  logic              spk_fifo_ready;
  logic              spk_fifo_push;
  logic              mic_fifo_valid;
  logic [DATA_W-1:0] mic_fifo_data;
  logic              mic_fifo_pop;
  adcs_pkg::adcs_state_type state_q;

  // buffered words count as temporary storage holding valid data
  assign wr_lock = spk_valid_o | mic_fifo_valid;
  assign wr_ok   = reg_wr_i & ~wr_lock;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      spk_pri_lo_q <= `ADCS_ADDR_RST;
      spk_pri_hi_q <= `ADCS_ADDR_RST;
      spk_sec_lo_q <= `ADCS_ADDR_RST;
      spk_sec_hi_q <= `ADCS_ADDR_RST;
    end else if (wr_ok) begin
      case (reg_addr_i)
        `ADCS_OFF_SPK_PRI_LO: spk_pri_lo_q <= reg_wdata_i;
        `ADCS_OFF_SPK_PRI_HI: spk_pri_hi_q <= reg_wdata_i;
        `ADCS_OFF_SPK_SEC_LO: spk_sec_lo_q <= reg_wdata_i;
        `ADCS_OFF_SPK_SEC_HI: spk_sec_hi_q <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // the hold bit stays writable under lock, else software could never abort
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      dma_hold_n_q <= `ADCS_HOLD_RST;
    end else if (reg_wr_i && (reg_addr_i == `ADCS_OFF_HOLD)) begin
      dma_hold_n_q <= reg_wdata_i[`ADCS_HOLD_BIT];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mic_channel_enable_q     <= `ADCS_EN_RST;
      speaker_channel_enable_q <= `ADCS_EN_RST;
    end else if (wr_ok && (reg_addr_i == `ADCS_OFF_ENABLES)) begin
      mic_channel_enable_q     <= reg_wdata_i[`ADCS_MIC_EN_BIT];
      speaker_channel_enable_q <= reg_wdata_i[`ADCS_SPK_EN_BIT];
    end
  end

  // bit 0 is kept as written; an odd count is the writer's fault
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mic_word_count_q     <= `ADCS_COUNT_RST;
      speaker_word_count_q <= `ADCS_COUNT_RST;
    end else if (wr_ok) begin
      case (reg_addr_i)
        `ADCS_OFF_MIC_COUNT: mic_word_count_q     <= reg_wdata_i;
        `ADCS_OFF_SPK_COUNT: speaker_word_count_q <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // ************************************************************
  // read port, data in the cycle after the strobe only
  // ************************************************************
  always_comb begin
    rdata_d = '0;
    case (reg_addr_i)
      `ADCS_OFF_SPK_PRI_LO: rdata_d = spk_pri_lo_q;
      `ADCS_OFF_SPK_PRI_HI: rdata_d = spk_pri_hi_q;
      `ADCS_OFF_SPK_SEC_LO: rdata_d = spk_sec_lo_q;
      `ADCS_OFF_SPK_SEC_HI: rdata_d = spk_sec_hi_q;
      `ADCS_OFF_HOLD:       rdata_d[`ADCS_HOLD_BIT] = dma_hold_n_q;
      `ADCS_OFF_ENABLES: begin
        rdata_d[`ADCS_MIC_EN_BIT] = mic_channel_enable_q;
        rdata_d[`ADCS_SPK_EN_BIT] = speaker_channel_enable_q;
      end
      `ADCS_OFF_STATUS: begin
        rdata_d[`ADCS_ST_SPK_RUN_BIT] = ch_run[0];
        rdata_d[`ADCS_ST_SPK_SEL_BIT] = ch_sel[0];
        rdata_d[`ADCS_ST_MIC_RUN_BIT] = ch_run[1];
        rdata_d[`ADCS_ST_MIC_SEL_BIT] = ch_sel[1];
      end
      `ADCS_OFF_MIC_COUNT:  rdata_d = mic_word_count_q;
      `ADCS_OFF_SPK_COUNT:  rdata_d = speaker_word_count_q;
      default:              rdata_d = '0;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rdata_d : 16'h0000;
    end
  end

  // ************************************************************
  // channel address and word-count engines
  // ************************************************************
  assign ch_pri[0]  = {spk_pri_hi_q, spk_pri_lo_q};
  assign ch_sec[0]  = {spk_sec_hi_q, spk_sec_lo_q};
  assign ch_pri[1]  = mic_primary_addr_i;
  assign ch_sec[1]  = mic_secondary_addr_i;
  assign ch_cnt[0]  = speaker_word_count_q;
  assign ch_cnt[1]  = mic_word_count_q;
  assign ch_auto[0] = speaker_autoload_select_i;
  assign ch_auto[1] = mic_autoload_select_i;
  assign ch_en[0]   = speaker_channel_enable_q;
  assign ch_en[1]   = mic_channel_enable_q;
  assign ch_done[0] = (state_q == adcs_pkg::ADCS_SPK_WAIT) & mem_rvalid_i;
  assign ch_done[1] = (state_q == adcs_pkg::ADCS_MIC_WR) & mem_gnt_i;

  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic [15:0] remain_q;
    logic        stop_q;

    always_ff @(posedge core_clk_i) begin
      if (rst_i || !dma_hold_n_q || !ch_en[c]) begin
        // hold or disable drops the channel back to its idle state
        ch_run[c]  <= 1'b0;
        stop_q     <= 1'b0;
        ch_sel[c]  <= 1'b0;
        ch_end[c]  <= 1'b0;
        remain_q   <= '0;
        ch_addr[c] <= '0;
      end else begin
        ch_end[c] <= 1'b0;
        if (!ch_run[c] && !stop_q) begin
          if (ch_cnt[c] == 16'h0000) begin
            stop_q <= 1'b1;
          end else begin
            ch_run[c]  <= 1'b1;
            ch_addr[c] <= ch_pri[c];
            remain_q   <= ch_cnt[c];
            ch_sel[c]  <= 1'b0;
          end
        end else if (ch_run[c] && ch_done[c]) begin
          if (remain_q == 16'h0001) begin
            ch_end[c] <= 1'b1;
            if (ch_auto[c] && (ch_cnt[c] != 16'h0000)) begin
              // auto-load flips to the other buffer when this one empties
              ch_sel[c]  <= ~ch_sel[c];
              ch_addr[c] <= ch_sel[c] ? ch_pri[c] : ch_sec[c];
              remain_q   <= ch_cnt[c];
            end else begin
              // auto-stop: primary only, then wait for the enable to cycle
              ch_run[c] <= 1'b0;
              stop_q    <= 1'b1;
            end
          end else begin
            ch_addr[c] <= ch_addr[c] + `ADCS_ADDR_STEP;
            remain_q   <= remain_q - 16'h0001;
          end
        end
      end
    end
  end

  assign spk_end_o = ch_end[0];
  assign mic_end_o = ch_end[1];

  // ************************************************************
  // word fifos
  // ************************************************************
  assign spk_fifo_push = ch_done[0] & ch_run[0];

  adcs_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_spk_fifo (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .flush_i    (~dma_hold_n_q | ~ch_en[0]),
    .block_i    (1'b0),
    .wr_data_i  (mem_rdata_i),
    .wr_valid_i (spk_fifo_push),
    .wr_ready_o (spk_fifo_ready),
    .rd_data_o  (spk_data_o),
    .rd_valid_o (spk_valid_o),
    .rd_ready_i (spk_ready_i)
  );

  // ready stays low under hold so the audio side keeps its request pending
  adcs_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_mic_fifo (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .flush_i    (~dma_hold_n_q | ~ch_en[1]),
    .block_i    (~dma_hold_n_q | ~ch_en[1] | ~ch_run[1]),
    .wr_data_i  (mic_data_i),
    .wr_valid_i (mic_valid_i),
    .wr_ready_o (mic_ready_o),
    .rd_data_o  (mic_fifo_data),
    .rd_valid_o (mic_fifo_valid),
    .rd_ready_i (mic_fifo_pop)
  );

  assign mic_fifo_pop = ch_done[1];

  // ************************************************************
  // memory engine, one access outstanding, microphone first
  // ************************************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !dma_hold_n_q) begin
      state_q   <= adcs_pkg::ADCS_IDLE;
      mem_cmd_o <= '0;
    end else begin
      case (state_q)
        adcs_pkg::ADCS_IDLE: begin
          // microphone first: its input cannot be paused by the memory side
          if (ch_run[1] && mic_fifo_valid) begin
            mem_cmd_o.req   <= 1'b1;
            mem_cmd_o.we    <= 1'b1;
            mem_cmd_o.addr  <= ch_addr[1];
            mem_cmd_o.wdata <= mic_fifo_data;
            state_q         <= adcs_pkg::ADCS_MIC_WR;
          end else if (ch_run[0] && spk_fifo_ready) begin
            mem_cmd_o.req   <= 1'b1;
            mem_cmd_o.we    <= 1'b0;
            mem_cmd_o.addr  <= ch_addr[0];
            mem_cmd_o.wdata <= '0;
            state_q         <= adcs_pkg::ADCS_SPK_RD;
          end
        end
        adcs_pkg::ADCS_SPK_RD: begin
          if (mem_gnt_i) begin
            mem_cmd_o.req <= 1'b0;
            state_q       <= adcs_pkg::ADCS_SPK_WAIT;
          end
        end
        adcs_pkg::ADCS_SPK_WAIT: begin
          if (mem_rvalid_i) begin
            state_q <= adcs_pkg::ADCS_IDLE;
          end
        end
        adcs_pkg::ADCS_MIC_WR: begin
          if (mem_gnt_i) begin
            mem_cmd_o.req <= 1'b0;
            mem_cmd_o.we  <= 1'b0;
            state_q       <= adcs_pkg::ADCS_IDLE;
          end
        end
        default: begin
          mem_cmd_o <= '0;
          state_q   <= adcs_pkg::ADCS_IDLE;
        end
      endcase
    end
  end

endmodule : adcs_top

// ---- src/adcs_cfg.svh ----
// register map, field positions, reset values and constants of the audio dma channel setup block
//
// Operation
// - speaker primary source address joins a low and a high 16-bit register
// - speaker secondary source address joins its own low and high registers
// - writing zero to the global hold bit stops every transfer at once
// - while the hold bit is zero, dma requests wait and none is served
// - hold bit sits at bit 0; zero holds, one runs; resets to one
// - microphone enable sits at bit 3 of the enable register; resets to zero
// - speaker enable sits at bit 2 of the enable register; resets to zero
// - microphone word count gives the 16-bit words moved per microphone buffer
// - speaker word count gives the 16-bit words moved per speaker buffer
// - reserved bits of hold and enable registers always read zero
// - speaker auto-load moves to the secondary buffer when primary empties
// - writes other than to the hold register are ignored while buffered data is held; software reads back

`ifndef ADCS_CFG_SVH
`define ADCS_CFG_SVH

// ************************************************************
// register byte addresses
// ************************************************************
`define ADCS_OFF_SPK_PRI_LO  32'h0A00_0028
`define ADCS_OFF_SPK_PRI_HI  32'h0A00_002A
`define ADCS_OFF_SPK_SEC_LO  32'h0A00_002C
`define ADCS_OFF_SPK_SEC_HI  32'h0A00_002E
`define ADCS_OFF_HOLD        32'h0A00_0040
`define ADCS_OFF_ENABLES     32'h0A00_0046
`define ADCS_OFF_STATUS      32'h0A00_0048
`define ADCS_OFF_MIC_COUNT   32'h0A00_0658
`define ADCS_OFF_SPK_COUNT   32'h0A00_065A

// ************************************************************
// field positions
// ************************************************************
`define ADCS_HOLD_BIT        0
`define ADCS_SPK_EN_BIT      2
`define ADCS_MIC_EN_BIT      3
`define ADCS_ST_SPK_RUN_BIT  0
`define ADCS_ST_SPK_SEL_BIT  1
`define ADCS_ST_MIC_RUN_BIT  2
`define ADCS_ST_MIC_SEL_BIT  3

// ************************************************************
// reset values and steps
// ************************************************************
`define ADCS_HOLD_RST        1'b1
`define ADCS_EN_RST          1'b0
`define ADCS_ADDR_RST        16'h0000
`define ADCS_COUNT_RST       16'hFFFF
`define ADCS_ADDR_STEP       32'h0000_0002
`define ADCS_FIFO_DEPTH      4

`endif

// ---- src/adcs_pkg.sv ----
// types shared by the audio dma channel setup block
package adcs_pkg;

  // memory engine states, gray along idle -> read -> wait, write next to idle
  typedef enum logic [1:0] {
    ADCS_IDLE     = 2'b00,
    ADCS_SPK_RD   = 2'b01,
    ADCS_SPK_WAIT = 2'b11,
    ADCS_MIC_WR   = 2'b10
  } adcs_state_type;

  // one command towards system memory
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [15:0] wdata;
  } adcs_mem_cmd_type;

endpackage : adcs_pkg

// ---- verification/adcs_top_properties.sv ----
// concurrent checks on the ports of the audio dma channel setup top
`timescale 1ns/1ps
`include "adcs_cfg.svh"
// ******
// checker
// ******
module adcs_top_checker #(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 16,
  parameter int DEPTH  = 4
) (
  input wire logic                       core_clk_i,
  input wire logic                       rst_i,
  input wire logic [ADDR_W-1:0]          reg_addr_i,
  input wire logic [15:0]                reg_wdata_i,
  input wire logic                       reg_wr_i,
  input wire logic                       reg_rd_i,
  input wire logic [15:0]                reg_rdata_o,
  input wire adcs_pkg::adcs_mem_cmd_type mem_cmd_o,
  input wire logic                       mem_gnt_i,
  input wire logic [DATA_W-1:0]          spk_data_o,
  input wire logic                       spk_valid_o,
  input wire logic                       spk_ready_i,
  input wire logic                       mic_ready_o,
  input wire logic                       spk_end_o,
  input wire logic                       mic_end_o
);
  logic       hold_q;
  logic [1:0] held_q;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // shadow of the hold bit; hold stays writable under the write lock
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hold_q <= 1'h1;
    end else if (reg_wr_i && reg_addr_i == `ADCS_OFF_HOLD) begin
      hold_q <= reg_wdata_i[0];
    end
  end
  // settle time of an abort before quiet is demanded
  always_ff @(posedge core_clk_i) begin
    if (rst_i || hold_q) begin
      held_q <= 2'h0;
    end else if (held_q != 2'h3) begin
      held_q <= held_q + 2'h1;
    end
  end
  property p_rd_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_hold_rd;
    $past(reg_rd_i) && $past(reg_addr_i) == `ADCS_OFF_HOLD |-> reg_rdata_o == {15'h0, $past(hold_q)};
  endproperty
  a_hold_rd: assert property (p_hold_rd) else $error("hold register read wrong");
  property p_en_rd;
    $past(reg_rd_i) && $past(reg_addr_i) == `ADCS_OFF_ENABLES
      |-> {reg_rdata_o[15:4], reg_rdata_o[1:0]} == 14'h0000;
  endproperty
  a_en_rd: assert property (p_en_rd) else $error("enable reserved bits set");
  property p_req_hold;
    mem_cmd_o.req && !mem_gnt_i && !reg_wr_i && !$past(reg_wr_i)
      |=> mem_cmd_o.req && $stable(mem_cmd_o.addr) && $stable(mem_cmd_o.wdata);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before grant");
  property p_gnt_drop;
    mem_cmd_o.req && mem_gnt_i |=> !mem_cmd_o.req;
  endproperty
  a_gnt_drop: assert property (p_gnt_drop) else $error("request kept after grant");
  property p_abort;
    reg_wr_i && reg_addr_i == `ADCS_OFF_HOLD && !reg_wdata_i[0]
      |-> ##3 (!mem_cmd_o.req && !spk_valid_o && !mic_ready_o);
  endproperty
  a_abort: assert property (p_abort) else $error("transfer not stopped by hold");
  property p_held;
    held_q == 2'h3 |-> !mem_cmd_o.req && !spk_valid_o && !mic_ready_o && !spk_end_o && !mic_end_o;
  endproperty
  a_held: assert property (p_held) else $error("activity while held");
  property p_spk_stall;
    spk_valid_o && !spk_ready_i && hold_q && !reg_wr_i && !$past(reg_wr_i)
      |=> spk_valid_o && $stable(spk_data_o);
  endproperty
  a_spk_stall: assert property (p_spk_stall) else $error("speaker word lost in stall");
  property p_spk_end;
    spk_end_o |=> !spk_end_o;
  endproperty
  a_spk_end: assert property (p_spk_end) else $error("speaker end not a pulse");
  property p_mic_end;
    mic_end_o |=> !mic_end_o;
  endproperty
  a_mic_end: assert property (p_mic_end) else $error("mic end not a pulse");
endmodule : adcs_top_checker

bind adcs_top adcs_top_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .DEPTH(DEPTH)) u_chk (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .mem_cmd_o(mem_cmd_o), .mem_gnt_i(mem_gnt_i),
  .spk_data_o(spk_data_o), .spk_valid_o(spk_valid_o), .spk_ready_i(spk_ready_i),
  .mic_ready_o(mic_ready_o), .spk_end_o(spk_end_o), .mic_end_o(mic_end_o));

// ---- verification/adcs_mem_model.sv ----
// system memory model answering the block's memory commands
`timescale 1ns/1ps
// ******
// memory model
// ******
module adcs_mem_model (
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       slow_i,
  input  wire adcs_pkg::adcs_mem_cmd_type cmd_i,
  output logic                            gnt_o,
  output logic                            rvalid_o,
  output logic [15:0]                     rdata_o
);
  logic [1:0] wait_q;
  // slow mode makes each grant wait four cycles
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      gnt_o  <= 1'h0;
      wait_q <= 2'h0;
    end else if (cmd_i.req && !gnt_o) begin
      gnt_o  <= !slow_i || wait_q == 2'h3;
      wait_q <= wait_q + 2'h1;
    end else begin
      gnt_o  <= 1'h0;
      wait_q <= 2'h0;
    end
  end
  // data from both address halves; idle data toggles so stale reads show
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rvalid_o <= 1'h0;
      rdata_o  <= 16'h0000;
    end else if (gnt_o && cmd_i.req && !cmd_i.we) begin
      rvalid_o <= 1'h1;
      rdata_o  <= cmd_i.addr[15:0] ^ cmd_i.addr[31:16] ^ 16'h5A5A;
    end else begin
      rvalid_o <= 1'h0;
      rdata_o  <= ~rdata_o;
    end
  end
endmodule : adcs_mem_model

// ---- verification/tb_top.sv ----
// self-checking bench for the audio dma channel setup block
`timescale 1ns/1ps
`include "adcs_cfg.svh"
// ******
// bench
// ******
module tb_top;
  logic        core_clk_i  = 1'h0;
  logic        rst_i       = 1'h1;
  logic [31:0] reg_addr_i  = 32'h0;
  logic [15:0] reg_wdata_i = 16'h0;
  logic        reg_wr_i    = 1'h0;
  logic        reg_rd_i    = 1'h0;
  logic        spk_al      = 1'h0;
  logic        slow        = 1'h0;
  logic        spk_rdy     = 1'h0;
  logic        mic_vld     = 1'h0;
  logic [15:0] mic_dat     = 16'h0;
  logic [15:0] reg_rdata_o, rdata, spk_dat;
  logic        gnt, rvalid, spk_vld, mic_rdy, spk_end, mic_end;
  adcs_pkg::adcs_mem_cmd_type mem_cmd;
  int          n_fail = 0, n_tests = 0, n_se = 0, n_me = 0, cyc = 0, rdy_mode = 0;
  logic [15:0] rq[$];
  logic [47:0] wq[$];

  adcs_top dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .mic_primary_addr_i(32'h0000_3000),
    .mic_secondary_addr_i(32'h0000_4000), .mic_autoload_select_i(1'h1),
    .speaker_autoload_select_i(spk_al), .mem_cmd_o(mem_cmd), .mem_gnt_i(gnt),
    .mem_rvalid_i(rvalid), .mem_rdata_i(rdata), .spk_data_o(spk_dat), .spk_valid_o(spk_vld),
    .spk_ready_i(spk_rdy), .mic_data_i(mic_dat), .mic_valid_i(mic_vld), .mic_ready_o(mic_rdy),
    .spk_end_o(spk_end), .mic_end_o(mic_end));
  adcs_mem_model mem (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .slow_i(slow), .cmd_i(mem_cmd),
    .gnt_o(gnt), .rvalid_o(rvalid), .rdata_o(rdata));

  always #2.5 core_clk_i = ~core_clk_i;
  // monitor: words, memory writes and end pulses; cuts a hang short
  always @(posedge core_clk_i) begin
    cyc     <= cyc + 1;
    spk_rdy <= rdy_mode == 1 || (rdy_mode == 2 && cyc % 3 != 0);
    if (spk_vld === 1'h1 && spk_rdy) rq.push_back(spk_dat);
    if (mem_cmd.req === 1'h1 && mem_cmd.we && gnt) wq.push_back({mem_cmd.addr, mem_cmd.wdata});
    if (spk_end === 1'h1) n_se <= n_se + 1;
    if (mic_end === 1'h1) n_me <= n_me + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  function automatic logic [15:0] ew(input logic [31:0] a);
    return a[15:0] ^ a[31:16] ^ 16'h5A5A;
  endfunction : ew
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'h1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'h0;
  endtask : wr
  task automatic rdchk(input logic [31:0] a, input logic [15:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'h1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'h0;
    #1 chk(reg_rdata_o, e);
  endtask : rdchk
  task automatic t_reset;
    rdchk(`ADCS_OFF_HOLD, 16'h0001);
    rdchk(`ADCS_OFF_ENABLES, 16'h0000);
    rdchk(`ADCS_OFF_MIC_COUNT, 16'hFFFF);
    rdchk(`ADCS_OFF_SPK_COUNT, 16'hFFFF);
    for (int i = 0; i < 4; i++) rdchk(`ADCS_OFF_SPK_PRI_LO + 2 * i, 16'h0000);
    rdchk(32'h0A00_0030, 16'h0000);
    $display("test reset values done");
  endtask : t_reset
  task automatic t_regs;
    for (int i = 0; i < 4; i++) wr(`ADCS_OFF_SPK_PRI_LO + 2 * i, 16'hA5C0 + 16'(i));
    for (int i = 0; i < 4; i++) rdchk(`ADCS_OFF_SPK_PRI_LO + 2 * i, 16'hA5C0 + 16'(i));
    wr(`ADCS_OFF_MIC_COUNT, 16'h1234);
    rdchk(`ADCS_OFF_MIC_COUNT, 16'h1234);
    wr(`ADCS_OFF_SPK_COUNT, 16'hFFFE);
    rdchk(`ADCS_OFF_SPK_COUNT, 16'hFFFE);
    wr(`ADCS_OFF_HOLD, 16'hFFFE);
    rdchk(`ADCS_OFF_HOLD, 16'h0000);
    // enables set only while held, so no transfer starts here
    wr(`ADCS_OFF_ENABLES, 16'hFFFF);
    rdchk(`ADCS_OFF_ENABLES, 16'h000C);
    wr(`ADCS_OFF_ENABLES, 16'h0000);
    wr(`ADCS_OFF_HOLD, 16'hFFFF);
    rdchk(`ADCS_OFF_HOLD, 16'h0001);
    $display("test register access done");
  endtask : t_regs
  task automatic t_spk;
    int e0;
    spk_al   <= 1'h1;
    rdy_mode <= 2;
    wr(`ADCS_OFF_SPK_PRI_LO, 16'h0100);
    wr(`ADCS_OFF_SPK_PRI_HI, 16'h0012);
    wr(`ADCS_OFF_SPK_SEC_LO, 16'h0200);
    wr(`ADCS_OFF_SPK_SEC_HI, 16'h0000);
    wr(`ADCS_OFF_SPK_COUNT, 16'h0004);
    rq.delete();
    e0 = n_se;
    wr(`ADCS_OFF_ENABLES, 16'h0004);
    for (int k = 0; k < 400 && rq.size() < 8; k++) @(posedge core_clk_i);
    rdy_mode <= 0;
    for (int i = 0; i < 8; i++)
      chk(rq[i], ew(i < 4 ? 32'h0012_0100 + 2 * i : 32'h0000_0200 + 2 * (i - 4)));
    repeat (12) @(posedge core_clk_i);
    chk(16'(n_se - e0 >= 2), 16'h0001);
    wr(`ADCS_OFF_SPK_COUNT, 16'h0010);
    rdchk(`ADCS_OFF_SPK_COUNT, 16'h0004);
    chk({15'h0, spk_vld}, 16'h0001);
    wr(`ADCS_OFF_HOLD, 16'h0000);
    repeat (4) @(posedge core_clk_i);
    chk({14'h0, spk_vld, mem_cmd.req}, 16'h0000);
    wr(`ADCS_OFF_ENABLES, 16'h0000);
    wr(`ADCS_OFF_HOLD, 16'h0001);
    $display("test speaker auto-load done");
  endtask : t_spk
  task automatic t_spk_stop;
    spk_al   <= 1'h0;
    slow     <= 1'h1;
    rdy_mode <= 1;
    rq.delete();
    wr(`ADCS_OFF_SPK_COUNT, 16'h0002);
    wr(`ADCS_OFF_ENABLES, 16'h0004);
    repeat (120) @(posedge core_clk_i);
    chk(16'(rq.size()), 16'h0002);
    chk(rq[0], ew(32'h0012_0100));
    chk(rq[1], ew(32'h0012_0102));
    wr(`ADCS_OFF_ENABLES, 16'h0000);
    slow <= 1'h0;
    $display("test speaker auto-stop done");
  endtask : t_spk_stop
  task automatic t_mic;
    int e0;
    logic [47:0] w;
    wr(`ADCS_OFF_HOLD, 16'h0000);
    wr(`ADCS_OFF_MIC_COUNT, 16'h0002);
    wr(`ADCS_OFF_ENABLES, 16'h0008);
    mic_dat <= 16'hC000;
    mic_vld <= 1'h1;
    repeat (8) @(posedge core_clk_i);
    chk({14'h0, mic_rdy, mem_cmd.req}, 16'h0000);
    wq.delete();
    e0 = n_me;
    wr(`ADCS_OFF_HOLD, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      mic_dat <= 16'hC000 + 16'(i);
      @(posedge core_clk_i);
      while (mic_rdy !== 1'h1) @(posedge core_clk_i);
    end
    mic_vld <= 1'h0;
    for (int k = 0; k < 200 && wq.size() < 4; k++) @(posedge core_clk_i);
    repeat (4) @(posedge core_clk_i);
    for (int i = 0; i < 4; i++) begin
      w = wq[i];
      chk(w[47:32], 16'h0000);
      chk(w[31:16], (i < 2 ? 16'h3000 : 16'h4000) + 16'(2 * (i % 2)));
      chk(w[15:0], 16'hC000 + 16'(i));
    end
    chk(16'(n_me - e0), 16'h0002);
    rdchk(`ADCS_OFF_STATUS, 16'h0004);
    wr(`ADCS_OFF_ENABLES, 16'h0000);
    $display("test microphone done");
  endtask : t_mic
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'h0;
    t_reset();
    t_regs();
    t_spk();
    t_spk_stop();
    t_mic();
    wrap_up();
  end
endmodule : tb_top
